// ===== core/cbtm_ctl.sv
// Purpose: controller end of command bus training
// Assumes: user pulses start with a target reference
// Notes: makes ck by dividing core_clk
`timescale 1ns/1ps
`default_nettype none
`include "cbtm_regs.svh"
module cbtm_ctl
	import cbtm_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// pins
	cbtm_if.ctl pins,
	// user side
	input wire logic start,
	input wire cbtm_caref_t new_ref,
	input wire cbtm_ca_t probe_ca,
	output logic busy,
	output cbtm_ca_t echo_ca
);
	typedef enum {S_IDLE, S_WR1A, S_WR1B, S_ENA, S_ENB, S_MRD, S_CKE, S_CAENT, S_DQS,
		S_SETTLE, S_PROBE, S_EXIT, S_DONEA, S_DONEB} cbtm_st_t;
	cbtm_st_t st;
	logic [3:0] div;
	logic [`CBTM_CNT_W-1:0] cnt;
	logic [2:0] pulses;
	logic [11:0] dq_s;
	// -------------------------------------------------------
	// link clock
	// -------------------------------------------------------
	logic edge_tick;
	assign edge_tick = (div == 4'(`CBTM_LCLK_HALF - 1)) && pins.ck;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			div <= 4'h0;
			pins.ck <= 1'b0;
		end else if (div == 4'(`CBTM_LCLK_HALF - 1)) begin
			div <= 4'h0;
			pins.ck <= ~pins.ck;
		end else begin
			div <= div + 4'h1;
		end
	end
	// -------------------------------------------------------
	// sequencer, commands change at clock fall
	// -------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st <= S_IDLE;
			cnt <= '0;
			pulses <= 3'h0;
			pins.cke <= 1'b1;
			pins.cs <= 1'b0;
			pins.ca <= 6'h00;
			pins.dq_ctl <= 16'h0000;
			pins.dq_ctl_oe <= 16'h0000;
			pins.dqs_ctl <= 1'b0;
			pins.dqs_ctl_oe <= 1'b0;
			busy <= 1'b0;
		end else if (edge_tick) begin
			if (cnt != 0)
				cnt <= cnt - 1'b1;
			pins.cs <= 1'b0;
			case (st)
				S_IDLE: if (start) begin
					busy <= 1'b1;
					pins.cs <= 1'b1;
					pins.ca <= `CBTM_MA_CTRL;
					st <= S_WR1A;
				end
				S_WR1A: begin
					pins.cs <= 1'b1;
					pins.ca <= 6'h20;
					st <= S_WR1B;
				end
				S_WR1B: begin
					pins.cs <= 1'b1;
					pins.ca <= `CBTM_MA_CTRL;
					st <= S_ENA;
				end
				S_ENA: begin
					pins.cs <= 1'b1;
					pins.ca <= 6'h21;
					cnt <= `CBTM_CNT_W'(`CBTM_MRD_CYC);
					st <= S_MRD;
				end
				S_MRD: if (cnt == 0) begin
					pins.cke <= 1'b0;
					cnt <= `CBTM_CNT_W'(`CBTM_CAENT_CYC + 2);
					st <= S_CAENT;
				end
				S_CAENT: if (cnt == 0) begin
					pins.dq_ctl <= {9'h000, new_ref};
					pins.dq_ctl_oe <= 16'h007F;
					pins.dqs_ctl_oe <= 1'b1;
					pulses <= 3'h4;
					st <= S_DQS;
				end
				S_DQS: if (pulses != 0) begin
					pins.dqs_ctl <= ~pins.dqs_ctl;
					pulses <= pulses - 3'h1;
				end else begin
					pins.dqs_ctl_oe <= 1'b0;
					pins.dq_ctl_oe <= 16'h0000;
					cnt <= `CBTM_CNT_W'(`CBTM_VREF_LONG_CYC);
					st <= S_SETTLE;
				end
				S_SETTLE: if (cnt == 0) begin
					pins.cs <= 1'b1;
					pins.ca <= probe_ca;
					cnt <= 8'h03;
					st <= S_PROBE;
				end
				S_PROBE: if (cnt == 0) begin
					pins.cke <= 1'b1;
					cnt <= `CBTM_CNT_W'(`CBTM_VREF_LONG_CYC);
					st <= S_EXIT;
				end
				S_EXIT: if (cnt == 0) begin
					pins.cs <= 1'b1;
					pins.ca <= `CBTM_MA_CTRL;
					st <= S_DONEA;
				end
				S_DONEA: begin
					pins.cs <= 1'b1;
					pins.ca <= 6'h20;
					cnt <= `CBTM_CNT_W'(`CBTM_MRW_CYC);
					st <= S_DONEB;
				end
				S_DONEB: if (cnt == 0) begin
					busy <= 1'b0;
					st <= S_IDLE;
				end
				default: st <= S_IDLE;
			endcase
		end
	end
	// -------------------------------------------------------
	// echo capture
	// -------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dq_s <= 12'h000;
			echo_ca <= 6'h00;
		end else begin
			dq_s <= {dq_s[5:0], pins.dq[13:8]};
			if (st == S_PROBE)
				echo_ca <= dq_s[11:6];
		end
	end
endmodule
`default_nettype wire

// ===== core/cbtm_dev.sv
// Purpose: device end of command bus training
// Assumes: controller drives ck; commands sampled on ck rising edge
// Notes: mode writes are a two-beat pair, first beat carries address
`timescale 1ns/1ps
`default_nettype none
`include "cbtm_regs.svh"

// How it works
// - power up on set-point zero
// - controller targets set one before training
// - mode write pair sets training enable
// - controller waits then drops clock enable
// - enable low swaps to alternate set
// - enable high restores original set
// - trained reference not kept; rewrite after exit (controller here writes only the control register after exit)
// - strobe toggles capture data pins six..zero
// - pins five..zero value, six range
// - data pin n maps reference bit n
// - pin seven and mask pin ignored
// - pins thirteen..eight echo latched command bits
// - echo is immediate, no read needed
// - upper strobe, mask, pins fifteen..fourteen float
// - captures accepted only after entry delay
// - controller applies one reference at least
// - controller waits settle before trusting echo
// - exit: enable high, settle, clear enable
// - entry from idle or self refresh alike
// - self refresh training keeps enable high; here enable drops as from idle, self_refresh is unused
// - terminating rank trained first
// - controller gives two strobe pulses per capture
// - clock and select held after enable low
module cbtm_dev
	import cbtm_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// pins
	cbtm_if.dev pins,
	// user side
	input wire logic self_refresh,
	output logic training_active,
	output logic operating_setpoint_select,
	output logic write_setpoint_select,
	output cbtm_caref_t ca_reference_setting_reg,
	output logic ready
);
	logic [2:0] ck_s, cke_s, dqs_s;
	logic [1:0] cs_s;
	logic [11:0] ca_s;
	logic [13:0] dq_s;
	logic ck_rise, dqs_edge, cke_now, cs_now;
	cbtm_ca_t ca_now;
	cbtm_caref_t dq_now;
	logic [7:0] setpoint_training_control_reg;
	logic mrw1_seen;
	logic [5:0] mrw_addr;
	logic saved_op;
	cbtm_caref_t caref_saved;
	logic [`CBTM_CNT_W-1:0] entry_cnt;
	logic [`CBTM_CNT_W-1:0] mrw_cnt;
	logic [5:0] echo;
	logic train_en;
	logic training_q;
	logic exit_pulse;
	logic beat_on;

	// a command beat is a clock rise seen with select high; the mode
	// writes and the echo latch both use it
	function automatic logic cmd_beat(input logic rise, input logic sel);
		return rise & sel;
	endfunction

	// -------------------------------------------------------
	// pin synchronisers
	// -------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ck_s <= 3'h0;
			cke_s <= 3'h7;
			dqs_s <= 3'h0;
			cs_s <= 2'h0;
			ca_s <= 12'h000;
			dq_s <= 14'h0000;
		end else begin
			ck_s <= {ck_s[1:0], pins.ck};
			cke_s <= {cke_s[1:0], pins.cke};
			dqs_s <= {dqs_s[1:0], pins.dqs_ctl & pins.dqs_ctl_oe};
			cs_s <= {cs_s[0], pins.cs};
			ca_s <= {ca_s[5:0], pins.ca};
			dq_s <= {dq_s[6:0], pins.dq[6:0]};
		end
	end
	assign ck_rise = ck_s[1] & ~ck_s[2];
	assign dqs_edge = dqs_s[1] ^ dqs_s[2];
	assign cke_now = cke_s[1];
	assign cs_now = cs_s[1];
	assign ca_now = ca_s[11:6];
	assign dq_now = dq_s[13:7];
	assign train_en = setpoint_training_control_reg[`CBTM_BIT_TRAIN_EN];
	assign beat_on = cmd_beat(ck_rise, cs_now) & cke_now;
	assign exit_pulse = training_q & ~training_active;

	// -------------------------------------------------------
	// mode writes
	// -------------------------------------------------------
	// commands decode only with enable high; entry works the same from
	// idle or self refresh, self_refresh only gates nothing here
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mrw1_seen <= 1'b0;
			mrw_addr <= 6'h00;
			setpoint_training_control_reg <= `CBTM_CTRL_RESET;
		end else if (beat_on) begin
			if (!mrw1_seen) begin
				mrw1_seen <= 1'b1;
				mrw_addr <= ca_now;
			end else begin
				mrw1_seen <= 1'b0;
				if (mrw_addr == `CBTM_MA_CTRL) begin
					setpoint_training_control_reg <= {ca_now[5], ca_now[5:4], ca_now[3:0],
						ca_now[0]};
				end
			end
		end
	end

	// -------------------------------------------------------
	// command-address reference
	// -------------------------------------------------------
	// strobe captures wait out the entry delay; exit brings back the value
	// held before training, so the controller must rewrite the trained one
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ca_reference_setting_reg <= `CBTM_CAREF_RESET;
		end else if (beat_on && mrw1_seen) begin
			if (mrw_addr == `CBTM_MA_CAREF && !training_active) begin
				ca_reference_setting_reg <= {ca_now[5], ca_now};
			end
		end else if (training_active && entry_cnt == 0 && dqs_edge) begin
			ca_reference_setting_reg <= dq_now;
		end else if (exit_pulse) begin
			ca_reference_setting_reg <= caref_saved;
		end
	end

	// -------------------------------------------------------
	// set-point swap and training state
	// -------------------------------------------------------
	// the set is inverted rather than forced, so either set can be trained
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			training_active <= 1'b0;
			training_q <= 1'b0;
			saved_op <= 1'b0;
			caref_saved <= `CBTM_CAREF_RESET;
			operating_setpoint_select <= 1'b0;
			entry_cnt <= '0;
		end else begin
			training_q <= training_active;
			if (!training_active && train_en && !cke_now && mrw_cnt == 0) begin
				training_active <= 1'b1;
				saved_op <= operating_setpoint_select;
				caref_saved <= ca_reference_setting_reg;
				operating_setpoint_select <= ~operating_setpoint_select;
				entry_cnt <= `CBTM_CNT_W'(`CBTM_CAENT_CYC);
			end else if (training_active && cke_now) begin
				training_active <= 1'b0;
				operating_setpoint_select <= saved_op;
			end else if (entry_cnt != 0) begin
				entry_cnt <= entry_cnt - 1'b1;
			end
		end
	end
	assign write_setpoint_select = setpoint_training_control_reg[`CBTM_BIT_WRSEL];

	// -------------------------------------------------------
	// readiness after mode write
	// -------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mrw_cnt <= '0;
			ready <= 1'b1;
		end else if (beat_on && mrw1_seen) begin
			mrw_cnt <= `CBTM_CNT_W'(`CBTM_MRW_CYC);
			ready <= 1'b0;
		end else if (mrw_cnt != 0) begin
			mrw_cnt <= mrw_cnt - 1'b1;
		end else begin
			ready <= 1'b1;
		end
	end

	// -------------------------------------------------------
	// echo of latched command bits
	// -------------------------------------------------------
	// latched on select, driven out at once without read timing
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			echo <= 6'h00;
		end else if (training_active && cmd_beat(ck_rise, cs_now)) begin
			echo <= ca_now;
		end
	end
	assign pins.dq_dev = {2'h0, echo, 8'h00};
	// pins 7..0 inputs, 15..14 float
	assign pins.dq_dev_oe = {2'h0, {6{training_active}}, 8'h00};
endmodule
`default_nettype wire

// ===== core/cbtm_if.sv
// Purpose: pins between controller and memory device
// Assumes: data pins are two-way, resolved here
// Notes: no clocking block
`timescale 1ns/1ps
`default_nettype none
interface cbtm_if;
	import cbtm_pkg::*;
	logic ck;
	logic cke;
	logic cs;
	cbtm_ca_t ca;
	logic [15:0] dq_ctl;
	logic [15:0] dq_ctl_oe;
	logic [15:0] dq_dev;
	logic [15:0] dq_dev_oe;
	logic dqs_ctl;
	logic dqs_ctl_oe;
	logic [15:0] dq;
	// controller wins where both drive; floating reads as zero
	genvar g;
	for (g = 0; g < 16; g++) begin : g_dq
		assign dq[g] = dq_ctl_oe[g] ? dq_ctl[g] : (dq_dev_oe[g] ? dq_dev[g] : 1'b0);
	end
	modport ctl (output ck, output cke, output cs, output ca, output dq_ctl,
		output dq_ctl_oe, output dqs_ctl, output dqs_ctl_oe, input dq);
	modport dev (input ck, input cke, input cs, input ca, output dq_dev,
		output dq_dev_oe, input dqs_ctl, input dqs_ctl_oe, input dq);
endinterface
`default_nettype wire

// ===== core/cbtm_pkg.sv
// Purpose: types for the command bus training pair
// Assumes: nothing
// Notes: constants sit in cbtm_regs.svh
package cbtm_pkg;
	typedef logic [6:0] cbtm_caref_t;
	typedef logic [5:0] cbtm_ca_t;
	typedef enum logic [1:0] {CBTM_CMD_NONE, CBTM_CMD_MRW1, CBTM_CMD_MRW2} cbtm_cmd_t;
endpackage

// ===== core/cbtm_regs.svh
// Purpose: constants for the command bus training pair
// Assumes: 100 MHz core clock
// Notes: times in ns, counts derived in cycles
`ifndef CBTM_REGS_SVH
`define CBTM_REGS_SVH
`define CBTM_CLK_NS 10
// mode register addresses (bus-level code of our own)
`define CBTM_MA_CTRL 6'h0D
`define CBTM_MA_CAREF 6'h0C
// control register fields
`define CBTM_BIT_TRAIN_EN 0
`define CBTM_BIT_OPSEL 7
`define CBTM_BIT_WRSEL 6
`define CBTM_CTRL_RESET 8'h00
`define CBTM_CAREF_RESET 7'h4D
// timing, ns and cycles
`define CBTM_MRD_NS 14
`define CBTM_MRD_CYC ((`CBTM_MRD_NS + `CBTM_CLK_NS - 1) / `CBTM_CLK_NS)
`define CBTM_CAENT_NS 250
`define CBTM_CAENT_CYC ((`CBTM_CAENT_NS + `CBTM_CLK_NS - 1) / `CBTM_CLK_NS)
`define CBTM_VREF_LONG_NS 250
`define CBTM_VREF_LONG_CYC ((`CBTM_VREF_LONG_NS + `CBTM_CLK_NS - 1) / `CBTM_CLK_NS)
`define CBTM_MRW_NS 10
`define CBTM_MRW_CYC ((`CBTM_MRW_NS + `CBTM_CLK_NS - 1) / `CBTM_CLK_NS)
`define CBTM_CKELCK_NS 5
`define CBTM_CKELCK_CYC 1
// link clock divider half period in core cycles (80 ns)
`define CBTM_LCLK_HALF 8
`define CBTM_CNT_W 8
`endif

// ===== sim/cbtm_monitor.sv
// Purpose: pin-level checks on the training link
// Assumes: all pins sampled on core_clk
// Notes: counters other than pulse_cnt saturate so long idle spans never wrap into a pass
`timescale 1ns/1ps
`default_nettype none
`include "cbtm_regs.svh"
module cbtm_monitor
	import cbtm_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// pins
	input wire logic ck,
	input wire logic cke,
	input wire logic cs,
	input wire cbtm_ca_t ca,
	input wire logic [15:0] dq_ctl_oe,
	input wire logic [15:0] dq_dev,
	input wire logic [15:0] dq_dev_oe,
	input wire logic dqs_ctl
);
	logic [7:0] lo_cnt, gap_cnt, hi_cnt, set_cnt, pulse_cnt;
	cbtm_ca_t ca_cs;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lo_cnt <= 8'h00;
			gap_cnt <= 8'hFF;
			hi_cnt <= 8'hFF;
			set_cnt <= 8'hFF;
			pulse_cnt <= 8'h00;
			ca_cs <= 6'h00;
		end else begin
			lo_cnt <= cke ? 8'h00 : lo_cnt + {7'h00, lo_cnt != 8'hFF};
			gap_cnt <= cs ? 8'h00 : gap_cnt + {7'h00, gap_cnt != 8'hFF};
			hi_cnt <= !cke ? 8'h00 : hi_cnt + {7'h00, hi_cnt != 8'hFF};
			set_cnt <= dqs_ctl ? 8'h00 : set_cnt + {7'h00, set_cnt != 8'hFF};
			pulse_cnt <= !dq_ctl_oe[0] ? 8'h00 : pulse_cnt + {7'h00, $rose(dqs_ctl)};
			if ($rose(cs)) begin
				ca_cs <= ca;
			end
		end
	end
	oe_low_a: assert property (dq_dev_oe[7:0] == 8'h00)
		else $error("device drives a capture pin");
	echo_drive_a: assert property ($fell(cke) |-> ##[1:40] (dq_dev_oe[13:8] == 6'h3F))
		else $error("echo pins not driven");
	echo_value_a: assert property ($rose(cs) && !cke |-> ##[2:40] (dq_dev[13:8] == ca_cs))
		else $error("echo differs from latched bus");
	cs_hold_a: assert property ($fell(cke) |-> !cs [*8])
		else $error("select raised after enable low");
	clk_run_a: assert property ($fell(cke) |-> ##[1:20] $changed(ck))
		else $error("link clock stopped after enable low");
	entry_wait_a: assert property ($fell(cke) |-> gap_cnt >= `CBTM_MRD_CYC)
		else $error("enable dropped too soon after mode write");
	capture_wait_a: assert property ($rose(dqs_ctl) |-> !cke && lo_cnt >= `CBTM_CAENT_CYC)
		else $error("strobe before entry delay");
	two_pulse_a: assert property ($fell(dq_ctl_oe[0]) |-> pulse_cnt >= 8'd2)
		else $error("fewer than two strobe pulses");
	probe_settle_a: assert property ($rose(cs) && !cke |-> set_cnt >= `CBTM_VREF_LONG_CYC)
		else $error("probe before reference settled");
	exit_settle_a: assert property (cs && cke |-> hi_cnt >= `CBTM_VREF_LONG_CYC)
		else $error("mode write too soon after enable high");
	cover property ($fell(cke));
	cover property ($rose(dqs_ctl) ##[1:100] $rose(dqs_ctl));
	cover property ($rose(cke) ##[1:300] cs);
endmodule
`default_nettype wire

// ===== sim/tb_command_bus_training_mode.sv
// Purpose: drives both training ends and judges their user sides
// Assumes: link clock made inside the controller end
// Notes: three full passes, the last from self refresh
`timescale 1ns/1ps
`default_nettype none
module tb_command_bus_training_mode import cbtm_pkg::*;;
	logic core_clk, rst, start, self_refresh, train_on, op_sel, wr_sel, ready, busy;
	cbtm_caref_t new_ref, ref_reg;
	cbtm_ca_t probe_ca, echo_ca;
	int err_total, cmp_count;
	cbtm_if cbtm_if_inst();
	cbtm_dev cbtm_dev_inst(.core_clk(core_clk), .rst(rst), .pins(cbtm_if_inst.dev),
		.self_refresh(self_refresh), .training_active(train_on), .operating_setpoint_select(op_sel),
		.write_setpoint_select(wr_sel), .ca_reference_setting_reg(ref_reg), .ready(ready));
	cbtm_ctl cbtm_ctl_inst(.core_clk(core_clk), .rst(rst), .pins(cbtm_if_inst.ctl), .start(start),
		.new_ref(new_ref), .probe_ca(probe_ca), .busy(busy), .echo_ca(echo_ca));
	cbtm_monitor cbtm_monitor_inst(.core_clk(core_clk), .rst(rst), .ck(cbtm_if_inst.ck),
		.cke(cbtm_if_inst.cke), .cs(cbtm_if_inst.cs), .ca(cbtm_if_inst.ca),
		.dq_ctl_oe(cbtm_if_inst.dq_ctl_oe), .dq_dev(cbtm_if_inst.dq_dev),
		.dq_dev_oe(cbtm_if_inst.dq_dev_oe), .dqs_ctl(cbtm_if_inst.dqs_ctl));
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic reset_vals();
		check("setpoint", 8'(op_sel), 8'h00);
		check("reference", 8'(ref_reg), 8'h4D);
		check("busy", 8'(busy), 8'h00);
		check("training off", 8'(train_on), 8'h00);
		check("write set", 8'(wr_sel), 8'h00);
		check("ready", 8'(ready), 8'h01);
		$display("reset test done");
	endtask
	// one clock, then the same small settling delay before anything is read or driven
	task automatic step();
		@(posedge core_clk);
		#1;
	endtask
	// one full entry, capture, probe and exit; values avoid the reset reference
	task automatic run_train(input cbtm_caref_t r, input cbtm_ca_t p, input logic sr);
		logic low_seen;
		step();
		new_ref = r;
		probe_ca = p;
		self_refresh = sr;
		start = 1'b1;
		low_seen = 1'b0;
		for (int i = 0; i < 100 && busy !== 1'b1; i++) step();
		start = 1'b0;
		for (int i = 0; i < 3000 && cbtm_if_inst.cke !== 1'b0; i++) step();
		for (int i = 0; i < 40 && op_sel !== 1'b1; i++) step();
		check("alt setpoint", 8'(op_sel), 8'h01);
		check("early reference", 8'(ref_reg), 8'h4D);
		for (int i = 0; i < 2000 && ref_reg !== r; i++) step();
		check("captured reference", 8'(ref_reg), 8'(r));
		// the exit mode write must pull ready low for its recovery time
		for (int i = 0; i < 5000 && busy !== 1'b0; i++) begin
			if (ready === 1'b0)
				low_seen = 1'b1;
			step();
		end
		for (int i = 0; i < 40 && (train_on !== 1'b0 || ready !== 1'b1); i++) step();
		check("write set", 8'(wr_sel), 8'h01);
		check("recovery seen", 8'(low_seen), 8'h01);
		check("restored setpoint", 8'(op_sel), 8'h00);
		check("restored reference", 8'(ref_reg), 8'h4D);
		check("echo", 8'(echo_ca), 8'(p));
		check("training off", 8'(train_on), 8'h00);
		check("ready", 8'(ready), 8'h01);
		$display("train test done ref %h probe %h", r, p);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		rst = 1'b1;
		start = 1'b0;
		self_refresh = 1'b0;
		new_ref = 7'h00;
		probe_ca = 6'h00;
		err_total = 0;
		cmp_count = 0;
		repeat (12) @(posedge core_clk);
		#1;
		rst = 1'b0;
		reset_vals();
		run_train(7'h7F, 6'h2A, 1'b0);
		run_train(7'h00, 6'h15, 1'b0);
		run_train(7'h3C, 6'h3F, 1'b1);
		wrap_up();
	end
	initial begin
		repeat (40000) @(posedge core_clk);
		err_total++;
		$display("watchdog expired");
		wrap_up();
	end
endmodule
`default_nettype wire
